// [logic/acs_pkg.sv]
// Shared constants, types and helpers for the conversion sequencer
package acs_pkg;
  // Register offsets
  localparam logic [7:0] PORT_DATA_OFS = 8'h05;
  localparam logic [7:0] CTRL_OFS = 8'h08;
  localparam logic [7:0] PORT_DIR_OFS = 8'h85;
  localparam logic [7:0] PORT_CFG_OFS = 8'h88;
  localparam logic [7:0] RESULT_OFS = 8'h89;
  localparam logic [7:0] AUX_STATUS_OFS = 8'h8A;
  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [1:0] PORT_CFG_RESET = 2'h0;
  localparam logic [4:0] PORT_DIR_RESET = 5'h1F;
  localparam logic [4:0] PORT_OUT_RESET = 5'h00;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  // Clock select codes
  localparam logic [1:0] SEL_DIV2 = 2'h0;
  localparam logic [1:0] SEL_DIV8 = 2'h1;
  localparam logic [1:0] SEL_DIV32 = 2'h2;
  localparam logic [1:0] SEL_RC = 2'h3;
  // Port configuration codes
  localparam logic [1:0] CFG_VREF_PIN = 2'h1;
  // Timing
  localparam int MCLK_PERIOD_NS = 10;
  localparam int TAD_MIN_BASIC_NS = 2000;
  localparam int TAD_MIN_OTHER_NS = 1600;
  localparam int RC_PERIOD_MIN_NS = 2000;
  localparam int RC_PERIOD_MAX_NS = 6000;
  localparam int RC_PERIOD_TYP_NS = 4000;
  localparam int RC_MIN_CYCLES = (RC_PERIOD_MIN_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int RC_MAX_CYCLES = RC_PERIOD_MAX_NS / MCLK_PERIOD_NS;
  localparam int RESULT_BITS = 8;

  typedef struct packed {
    logic [1:0] clkSel;
    logic spare;
    logic [1:0] chan;
    logic go;
    logic doneFlag;
    logic enable;
  } acs_ctrl_type;

  typedef enum logic [4:0] {
    ST_OFF = 5'h01,
    ST_ACQ = 5'h02,
    ST_SETTLE = 5'h04,
    ST_CONV = 5'h08,
    ST_HOLD = 5'h10
  } acs_state_type;

  // Oscillator periods per conversion clock period
  function automatic logic [5:0] tadDivider(input logic [1:0] sel);
    case (sel)
      SEL_DIV2: tadDivider = 6'h02;
      SEL_DIV8: tadDivider = 6'h08;
      default: tadDivider = 6'h20;
    endcase
  endfunction : tadDivider

  // Pins 3..0 that are analog for a given configuration
  function automatic logic [3:0] analogMask(input logic [1:0] cfg);
    case (cfg)
      2'h0: analogMask = 4'hF;
      2'h1: analogMask = 4'hF;
      2'h2: analogMask = 4'h3;
      default: analogMask = 4'h0;
    endcase
  endfunction : analogMask
endpackage : acs_pkg

// [logic/acs_sar_core.sv]
// Successive-approximation trial register
`timescale 1ns/1ps
module acs_sar_core #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  input wire logic clkEn,
  // Control
  input wire logic start,
  input wire logic step,
  input wire logic compHigh,
  // Trial and status
  output logic [WIDTH-1:0] dacCode,
  output logic lastStep
);
  logic [WIDTH-1:0] trial_reg;
  logic [WIDTH-1:0] mask_reg;
  localparam logic [WIDTH-1:0] TOP_BIT = {1'b1, {(WIDTH-1){1'b0}}};

  assign dacCode = trial_reg;
  assign lastStep = mask_reg[0];

  always_ff @(posedge mclk) begin
    if (rst) begin
      trial_reg <= '0;
      mask_reg <= '0;
    end else if (clkEn) begin
      if (start) begin
        trial_reg <= TOP_BIT;
        mask_reg <= TOP_BIT;
      end else if (step && mask_reg != '0) begin
        // One result bit per step, top bit first
        trial_reg <= (compHigh ? trial_reg : (trial_reg & ~mask_reg)) | (mask_reg >> 1);
        mask_reg <= mask_reg >> 1;
      end
    end
  end
endmodule : acs_sar_core

// [logic/acs_sequencer.sv]
// Conversion sequencer: registers, port masking, clock select and state machine
// Function
// - An output-driven analog pin converts its own driven digital level.
// - Direction and channel bits never block starting or finishing a conversion.
// - Port data reads return zero on every analog-configured pin.
// - A digital-input pin selected as channel still converts as analog.
// - Clearing the start bit mid-conversion aborts at once.
// - An abort leaves the result register untouched.
// - After an abort wait two conversion clocks before reconnecting the sample capacitor.
// - After that wait acquisition restarts on the selected channel by itself.
// - Completion sets the done flag and clears the start bit.
// - Two conversion clocks of settling, then one result bit per clock, eight bits.
// - Mid-conversion clock changes only among oscillator dividers, never to or from RC.
// - Bits resolved after the conversion clock becomes too fast are invalid.
// - Internal RC conversion clock period lies between 2 and 6 us.
// - Clock select 00, 01, 10 give oscillator divided by 2, 8, 32.
// - Clock select 11 gives the internal RC oscillator.
// - Setting the start bit while enabled starts; it reads one until done or abort. Here a start is taken only in acquisition, not in the hold-off.
// - Port configuration picks analog pins and reference per its four codes.
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module acs_sequencer #(
  parameter int TAD_MIN_NS = acs_pkg::TAD_MIN_OTHER_NS
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  input wire logic clkEn,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  // Port pins
  input wire logic [4:0] pinIn,
  output logic [4:0] pinOut,
  output logic [4:0] pinOe,
  // Internal RC oscillator
  input wire logic rcClkIn,
  // Analog front end
  input wire logic compHigh,
  output logic [7:0] dacCode,
  output logic [1:0] sampleChannel,
  output logic sampleConnect,
  output logic vrefExternal
);
  acs_pkg::acs_state_type state_reg;
  acs_pkg::acs_state_type state_next;
  acs_pkg::acs_ctrl_type ctrl_reg;
  acs_pkg::acs_ctrl_type ctrl_next;
  acs_pkg::acs_ctrl_type wrCtrl;
  logic [1:0] portCfg_reg;
  logic [4:0] portDir_reg;
  logic [4:0] portOut_reg;
  logic [7:0] result_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [4:0] pinSync1_reg;
  logic [4:0] pinSync2_reg;
  logic rcSync1_reg;
  logic rcSync2_reg;
  logic rcPrev_reg;
  logic rcTick;
  logic [9:0] rcPeriod_reg;
  logic rcFault_reg;
  logic [1:0] effSel_reg;
  logic [1:0] effSel_next;
  logic half_reg;
  logic sampleConnect_reg;
  logic violated_reg;
  logic [3:0] validBits_reg;
  logic tadTick;
  logic tadRun;
  logic sarLast;
  logic busy;
  logic ctrlWrite;
  logic startReq;
  logic abortReq;
  logic finish;
  logic tadShort;
  logic [7:0] sarCode;

  assign wrCtrl = acs_pkg::acs_ctrl_type'(regWdata);
  assign ctrlWrite = regWrite && regAddr == acs_pkg::CTRL_OFS;
  assign busy = state_reg == acs_pkg::ST_SETTLE || state_reg == acs_pkg::ST_CONV;
  // Start needs the module already on; a same-write enable does not count
  assign startReq = ctrlWrite && wrCtrl.go && wrCtrl.enable && ctrl_reg.enable &&
                    state_reg == acs_pkg::ST_ACQ;
  // Direction and channel bits play no part in start or abort
  assign abortReq = busy && ctrlWrite && (!wrCtrl.go || !wrCtrl.enable);
  assign finish = state_reg == acs_pkg::ST_CONV && tadTick && sarLast;
  // Abort restarts the divider count so a divider-clock hold-off spans two whole periods (RC ticks keep their own phase); abort also beats a last tick
  assign tadRun = state_reg != acs_pkg::ST_ACQ && state_reg != acs_pkg::ST_OFF && !abortReq;
  assign tadShort = effSel_reg != acs_pkg::SEL_RC &&
                    (32'(acs_pkg::tadDivider(effSel_reg)) * acs_pkg::MCLK_PERIOD_NS) < TAD_MIN_NS;

  // Pin and RC clock synchronisers
  always_ff @(posedge mclk) begin
    if (rst) begin
      pinSync1_reg <= 5'h00;
      pinSync2_reg <= 5'h00;
      rcSync1_reg <= 1'b0;
      rcSync2_reg <= 1'b0;
      rcPrev_reg <= 1'b0;
    end else if (clkEn) begin
      pinSync1_reg <= pinIn;
      pinSync2_reg <= pinSync1_reg;
      rcSync1_reg <= rcClkIn;
      rcSync2_reg <= rcSync1_reg;
      rcPrev_reg <= rcSync2_reg;
    end
  end

  assign rcTick = rcSync2_reg && !rcPrev_reg;

  // RC period watch; the RC source is free of the oscillator, so only its range is checked
  always_ff @(posedge mclk) begin
    if (rst) begin
      rcPeriod_reg <= 10'h000;
      rcFault_reg <= 1'b0;
    end else if (clkEn) begin
      if (rcTick) begin
        rcPeriod_reg <= 10'h001;
        if (rcPeriod_reg != 10'h000 &&
            (32'(rcPeriod_reg) < acs_pkg::RC_MIN_CYCLES || 32'(rcPeriod_reg) > acs_pkg::RC_MAX_CYCLES)) begin
          rcFault_reg <= 1'b1;
        end
      end else if (rcPeriod_reg != 10'h000 && rcPeriod_reg != 10'h3FF) begin
        // Count only from a first edge: the span after reset is a partial period
        rcPeriod_reg <= rcPeriod_reg + 10'h001;
      end
      if (regWrite && regAddr == acs_pkg::AUX_STATUS_OFS && !regWdata[0] && !rcTick) begin
        rcFault_reg <= 1'b0;
      end
    end
  end

  acs_tad_gen #(
    .CNT_W(6)
  ) tadGen (
    .mclk(mclk),
    .rst(rst),
    .clkEn(clkEn),
    .run(tadRun),
    .clkSel(effSel_reg),
    .rcTick(rcTick),
    .tadTick(tadTick)
  );

  acs_sar_core #(
    .WIDTH(acs_pkg::RESULT_BITS)
  ) sarCore (
    .mclk(mclk),
    .rst(rst),
    .clkEn(clkEn),
    .start(startReq),
    .step(state_reg == acs_pkg::ST_CONV && tadTick),
    .compHigh(compHigh),
    .dacCode(sarCode),
    .lastStep(sarLast)
  );

  // Control register next value
  always_comb begin
    ctrl_next = ctrl_reg;
    if (ctrlWrite) begin
      ctrl_next.clkSel = wrCtrl.clkSel;
      ctrl_next.chan = wrCtrl.chan;
      ctrl_next.enable = wrCtrl.enable;
      ctrl_next.doneFlag = wrCtrl.doneFlag;
      if (!wrCtrl.go) begin
        ctrl_next.go = 1'b0;
      end
    end
    ctrl_next.spare = 1'b0;
    if (startReq) begin
      ctrl_next.go = 1'b1;
    end
    if (abortReq) begin
      ctrl_next.go = 1'b0;
    end
    // Hardware set beats a software clear in the same cycle
    if (finish) begin
      ctrl_next.go = 1'b0;
      ctrl_next.doneFlag = 1'b1;
    end
  end

  // Effective clock: RC cannot be entered or left while converting
  always_comb begin
    effSel_next = ctrl_next.clkSel;
    if (state_next == acs_pkg::ST_SETTLE || state_next == acs_pkg::ST_CONV) begin
      if (state_reg != acs_pkg::ST_ACQ &&
          ((effSel_reg == acs_pkg::SEL_RC) != (ctrl_next.clkSel == acs_pkg::SEL_RC))) begin
        effSel_next = effSel_reg;
      end
    end
  end

  // Sequencer state machine
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      acs_pkg::ST_OFF: begin
        if (ctrl_reg.enable) begin
          state_next = acs_pkg::ST_ACQ;
        end
      end
      acs_pkg::ST_ACQ: begin
        if (!ctrl_reg.enable) begin
          state_next = acs_pkg::ST_OFF;
        end else if (startReq) begin
          state_next = acs_pkg::ST_SETTLE;
        end
      end
      acs_pkg::ST_SETTLE: begin
        if (abortReq) begin
          state_next = acs_pkg::ST_HOLD;
        end else if (tadTick && half_reg) begin
          state_next = acs_pkg::ST_CONV;
        end
      end
      acs_pkg::ST_CONV: begin
        if (abortReq || finish) begin
          state_next = acs_pkg::ST_HOLD;
        end
      end
      acs_pkg::ST_HOLD: begin
        if (tadTick && half_reg) begin
          state_next = ctrl_reg.enable ? acs_pkg::ST_ACQ : acs_pkg::ST_OFF;
        end
      end
      default: begin
        state_next = acs_pkg::ST_OFF;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= acs_pkg::ST_OFF;
      half_reg <= 1'b0;
      effSel_reg <= acs_pkg::SEL_DIV2;
      sampleConnect_reg <= 1'b0;
    end else if (clkEn) begin
      state_reg <= state_next;
      effSel_reg <= effSel_next;
      // Capacitor is reconnected only in acquisition, never during the hold-off
      sampleConnect_reg <= state_next == acs_pkg::ST_ACQ;
      if (state_next != state_reg) begin
        half_reg <= 1'b0;
      end else if (tadTick) begin
        half_reg <= !half_reg;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_reg <= acs_pkg::acs_ctrl_type'(acs_pkg::CTRL_RESET);
    end else if (clkEn) begin
      ctrl_reg <= ctrl_next;
    end
  end

  // Result: loaded only on completion or by software
  always_ff @(posedge mclk) begin
    if (rst) begin
      result_reg <= acs_pkg::RESULT_RESET;
    end else if (clkEn) begin
      if (finish) begin
        // Lowest bit is still a trial here; the comparator decides it on this tick
        result_reg <= {sarCode[7:1], compHigh};
      end else if (regWrite && regAddr == acs_pkg::RESULT_OFS) begin
        result_reg <= regWdata;
      end
    end
  end

  // Count bits resolved before the first too-fast conversion clock
  always_ff @(posedge mclk) begin
    if (rst) begin
      violated_reg <= 1'b0;
      validBits_reg <= 4'h0;
    end else if (clkEn) begin
      if (startReq) begin
        violated_reg <= 1'b0;
        validBits_reg <= 4'h0;
      end else if (state_reg == acs_pkg::ST_CONV && tadTick) begin
        if (tadShort) begin
          violated_reg <= 1'b1;
        end else if (!violated_reg) begin
          validBits_reg <= validBits_reg + 4'h1;
        end
      end
    end
  end

  // Port configuration, direction and output latch
  always_ff @(posedge mclk) begin
    if (rst) begin
      portCfg_reg <= acs_pkg::PORT_CFG_RESET;
      portDir_reg <= acs_pkg::PORT_DIR_RESET;
      portOut_reg <= acs_pkg::PORT_OUT_RESET;
    end else if (clkEn && regWrite) begin
      if (regAddr == acs_pkg::PORT_CFG_OFS) begin
        portCfg_reg <= regWdata[1:0];
      end
      if (regAddr == acs_pkg::PORT_DIR_OFS) begin
        portDir_reg <= regWdata[4:0];
      end
      if (regAddr == acs_pkg::PORT_DATA_OFS) begin
        portOut_reg <= regWdata[4:0];
      end
    end
  end

  // Read path
  always_comb begin
    rdata_next = 8'h00;
    case (regAddr)
      acs_pkg::CTRL_OFS: rdata_next = ctrl_reg;
      acs_pkg::PORT_CFG_OFS: rdata_next = {6'h00, portCfg_reg};
      acs_pkg::PORT_DIR_OFS: rdata_next = {3'h0, portDir_reg};
      acs_pkg::RESULT_OFS: rdata_next = result_reg;
      acs_pkg::AUX_STATUS_OFS: rdata_next = {validBits_reg, 3'h0, rcFault_reg};
      acs_pkg::PORT_DATA_OFS: rdata_next = {3'h0, pinSync2_reg & {1'b1, ~acs_pkg::analogMask(portCfg_reg)}};
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_reg <= 8'h00;
    end else if (clkEn) begin
      rdata_reg <= regRead ? rdata_next : 8'h00;
    end
  end

  assign regRdata = rdata_reg;
  // Output drivers stay on for output pins even when analog: the mux sees the driven level
  assign pinOut = portOut_reg;
  assign pinOe = ~portDir_reg;
  // Channel mux follows the select bits alone, whatever the pin direction or digital setting
  assign sampleChannel = ctrl_reg.chan;
  assign sampleConnect = sampleConnect_reg;
  assign vrefExternal = portCfg_reg == acs_pkg::CFG_VREF_PIN;
  assign dacCode = sarCode;

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence startSeq;
    clkEn && startReq;
  endsequence

  startGo_a: assert property (startSeq |=> ctrl_reg.go && state_reg == acs_pkg::ST_SETTLE)
    else $error("start did not raise the start bit");
  abortState_a: assert property (clkEn && abortReq |=> state_reg == acs_pkg::ST_HOLD && !ctrl_reg.go)
    else $error("abort did not stop the conversion");
  abortKeep_a: assert property (clkEn && abortReq |=> result_reg == $past(result_reg))
    else $error("abort changed the result");
  finishFlag_a: assert property (clkEn && finish |=> ctrl_reg.doneFlag && !ctrl_reg.go &&
                                 result_reg == {$past(sarCode[7:1]), $past(compHigh)})
    else $error("completion flags wrong");
  holdOpen_a: assert property (state_reg == acs_pkg::ST_HOLD |-> !sampleConnect)
    else $error("capacitor connected during hold-off");
  autoAcq_a: assert property (clkEn && state_reg == acs_pkg::ST_HOLD && tadTick && half_reg && ctrl_reg.enable
                              |=> sampleConnect && state_reg == acs_pkg::ST_ACQ)
    else $error("acquisition did not restart");
  portMask_a: assert property (clkEn && regRead && regAddr == acs_pkg::PORT_DATA_OFS
                               |=> (regRdata[3:0] & $past(acs_pkg::analogMask(portCfg_reg))) == 4'h0)
    else $error("analog pin read as nonzero");
  offNoGo_a: assert property (!ctrl_reg.enable && state_reg != acs_pkg::ST_HOLD |-> !ctrl_reg.go)
    else $error("start bit set while disabled");
  rcLock_a: assert property (clkEn && busy && state_next != acs_pkg::ST_HOLD && state_reg != acs_pkg::ST_ACQ
                             |=> (effSel_reg == acs_pkg::SEL_RC) == ($past(effSel_reg) == acs_pkg::SEL_RC))
    else $error("clock switched to or from RC mid-conversion");

  sequence settleSeq;
    clkEn && state_reg == acs_pkg::ST_SETTLE && tadTick && half_reg && !abortReq;
  endsequence
  settleConv_a: assert property (settleSeq |=> state_reg == acs_pkg::ST_CONV && dacCode == 8'h80)
    else $error("conversion did not begin after two clocks");
endmodule : acs_sequencer

// [logic/acs_tad_gen.sv]
// Conversion clock tick generator
`timescale 1ns/1ps
module acs_tad_gen #(
  parameter int CNT_W = 6
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  input wire logic clkEn,
  // Control
  input wire logic run,
  input wire logic [1:0] clkSel,
  input wire logic rcTick,
  // Tick out
  output logic tadTick
);
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] limit;

  assign limit = CNT_W'(acs_pkg::tadDivider(clkSel) - 6'h01);
  // Compare with >= so a switch to a faster divider ticks at once if the count has already reached the new limit
  assign tadTick = run && ((clkSel == acs_pkg::SEL_RC) ? rcTick : (count_reg >= limit));

  always_ff @(posedge mclk) begin
    if (rst) begin
      count_reg <= '0;
    end else if (clkEn) begin
      if (!run || tadTick || clkSel == acs_pkg::SEL_RC) begin
        count_reg <= '0;
      end else begin
        count_reg <= count_reg + CNT_W'(1);
      end
    end
  end
endmodule : acs_tad_gen

// [verif/tb_acs_sequencer.sv]
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module tb_acs_sequencer;
  typedef struct packed {
    logic [1:0] sel;
    logic [1:0] ch;
    logic [4:0] dir;
    logic [7:0] ain;
    logic [7:0] res;
  } acs_row_type;

  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic clkEn = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [4:0] pinIn = 5'h1F;
  logic rcClkIn = 1'b0;
  logic compHigh;
  logic [7:0] regRdata;
  logic [7:0] dacCode;
  logic [4:0] pinOut;
  logic [4:0] pinOe;
  logic [1:0] sampleChannel;
  logic sampleConnect;
  logic vrefExternal;
  logic [3:0][7:0] ain = '0;
  acs_row_type rows [5];
  acs_row_type r;
  int mismatches = 0;
  int cmpCount = 0;
  int n;
  int dv;
  time tS;
  logic [7:0] d;
  logic [3:0] am;

  always #5 mclk = ~mclk;
  // Free-running RC source, 4 us period, phase unrelated to mclk
  always #2000.3 rcClkIn = ~rcClkIn;
  // Ideal comparator: analog level of the muxed channel against the trial code
  assign compHigh = (ain[sampleChannel] >= dacCode);

  acs_sequencer u_acs_sequencer (
    .mclk(mclk),
    .rst(rst),
    .clkEn(clkEn),
    .regAddr(regAddr),
    .regWdata(regWdata),
    .regWrite(regWrite),
    .regRead(regRead),
    .regRdata(regRdata),
    .pinIn(pinIn),
    .pinOut(pinOut),
    .pinOe(pinOe),
    .rcClkIn(rcClkIn),
    .compHigh(compHigh),
    .dacCode(dacCode),
    .sampleChannel(sampleChannel),
    .sampleConnect(sampleConnect),
    .vrefExternal(vrefExternal)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= v;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge mclk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge mclk);
    regRead <= 1'b0;
    #1;
    v = regRdata;
  endtask : rd

  task automatic waitConnect();
    int c;
    c = 0;
    while (sampleConnect !== 1'b1 && c < 2000) begin
      @(posedge mclk);
      #1;
      c++;
    end
    chk(sampleConnect, 1'b1);
  endtask : waitConnect

  // Poll the start bit; n gets the cycles since tS
  task automatic pollDone();
    int k;
    k = 0;
    do begin
      rd(acs_pkg::CTRL_OFS, d);
      k++;
    end while (d[2] !== 1'b0 && k < 3000);
    n = int'(($time - tS) / 10);
  endtask : pollDone

  task automatic results();
    if (mismatches == 0 && cmpCount > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  // Whole run is about 5500 cycles, the RC row being the longest; allow ample margin
  initial begin
    #200000;
    mismatches++;
    results();
  end

  initial begin
    rows[0] = '{2'h0, 2'h0, 5'h1F, 8'hA5, 8'hA5};
    rows[1] = '{2'h1, 2'h1, 5'h00, 8'h3C, 8'h3C};
    rows[2] = '{2'h2, 2'h2, 5'h1F, 8'hFF, 8'hFF};
    rows[3] = '{2'h3, 2'h3, 5'h1F, 8'h01, 8'h01};
    rows[4] = '{2'h0, 2'h3, 5'h00, 8'h00, 8'h00};
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    rd(acs_pkg::CTRL_OFS, d);
    chk(d, acs_pkg::CTRL_RESET);
    rd(acs_pkg::PORT_DIR_OFS, d);
    chk(d, 8'h1F);
    rd(acs_pkg::RESULT_OFS, d);
    chk(d, acs_pkg::RESULT_RESET);
    rd(8'h40, d);
    chk(d, 8'h00);
    chk(sampleConnect, 1'b0);
    // Analog pins read low, RA4 stays digital
    for (int c = 3; c >= 0; c--) begin
      am = (c == 2) ? 4'h3 : (c == 3) ? 4'h0 : 4'hF;
      wr(acs_pkg::PORT_CFG_OFS, 8'(c));
      rd(acs_pkg::PORT_DATA_OFS, d);
      chk(d, {3'h0, 1'b1, ~am});
      chk(vrefExternal, c == 1);
    end
    wr(acs_pkg::PORT_DIR_OFS, 8'h00);
    wr(acs_pkg::PORT_DATA_OFS, 8'h0A);
    #1;
    chk(pinOe, 5'h1F);
    chk(pinOut, 5'h0A);
    // Ordinary conversions, one row per clock source and a second divide-by-2 row
    for (int i = 0; i < 5; i++) begin
      r = rows[i];
      dv = (r.sel == 2'h0) ? 2 : (r.sel == 2'h1) ? 8 : 32;
      ain[r.ch] = r.ain;
      wr(acs_pkg::PORT_DIR_OFS, {3'h0, r.dir});
      wr(acs_pkg::CTRL_OFS, {r.sel, 1'b0, r.ch, 3'h1});
      waitConnect();
      repeat (4) @(posedge mclk);
      wr(acs_pkg::CTRL_OFS, {r.sel, 1'b0, r.ch, 3'h5});
      tS = $time;
      pollDone();
      if (r.sel == acs_pkg::SEL_RC) begin
        chk(n >= 9 * acs_pkg::RC_MIN_CYCLES && n <= 11 * acs_pkg::RC_MAX_CYCLES, 1'b1);
      end else begin
        chk(n >= 10 * dv && n <= 10 * dv + 6, 1'b1);
      end
      chk(d, {r.sel, 1'b0, r.ch, 3'h3});
      rd(acs_pkg::RESULT_OFS, d);
      chk(d, r.res);
      rd(acs_pkg::AUX_STATUS_OFS, d);
      chk(d, (r.sel == acs_pkg::SEL_RC) ? 8'h80 : 8'h00);
    end
    // Abort mid-conversion keeps the software-written result
    wr(acs_pkg::RESULT_OFS, 8'h5A);
    ain[1] = 8'hC3;
    wr(acs_pkg::CTRL_OFS, 8'h89);
    waitConnect();
    wr(acs_pkg::CTRL_OFS, 8'h8D);
    repeat (20) @(posedge mclk);
    wr(acs_pkg::CTRL_OFS, 8'h89);
    tS = $time;
    rd(acs_pkg::CTRL_OFS, d);
    chk(d, 8'h89);
    chk(sampleConnect, 1'b0);
    waitConnect();
    n = int'(($time - tS) / 10);
    chk(n >= 64 && n <= 68, 1'b1);
    chk(sampleChannel, 2'h1);
    rd(acs_pkg::RESULT_OFS, d);
    chk(d, 8'h5A);
    // Asking for RC mid-conversion keeps the divider clock
    wr(acs_pkg::CTRL_OFS, 8'h0D);
    tS = $time;
    wr(acs_pkg::CTRL_OFS, 8'hCD);
    pollDone();
    chk(n >= 20 && n <= 26, 1'b1);
    chk(d, 8'hCB);
    rd(acs_pkg::RESULT_OFS, d);
    chk(d, 8'hC3);
    // Start together with enable, then start while disabled
    wr(acs_pkg::CTRL_OFS, 8'h00);
    wr(acs_pkg::CTRL_OFS, 8'h05);
    repeat (40) @(posedge mclk);
    rd(acs_pkg::CTRL_OFS, d);
    chk(d, 8'h01);
    wr(acs_pkg::CTRL_OFS, 8'h04);
    repeat (40) @(posedge mclk);
    rd(acs_pkg::CTRL_OFS, d);
    chk(d, 8'h00);
    // Second reset in mid-run
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd(acs_pkg::CTRL_OFS, d);
    chk(d, acs_pkg::CTRL_RESET);
    rd(acs_pkg::RESULT_OFS, d);
    chk(d, acs_pkg::RESULT_RESET);
    results();
  end
endmodule : tb_acs_sequencer
